// file: core/cvb_bit_history_core.sv
// sign bit capture, three-bit history and coincidence detection
`timescale 1ns/10ps

module cvb_bit_history_core #(
    parameter int                  HIST_LEN  = cvb_pkg::HIST_LEN,
    parameter logic [HIST_LEN-1:0] HIST_INIT = cvb_pkg::HIST_RESET,
    parameter int                  SYNC_LEN  = cvb_pkg::SYNC_LEN
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             syncReset,
    input  wire logic             bitClk,
    input  wire logic             encodeSelect,
    input  wire logic             inputAboveFeedback,
    input  wire logic             rxData,
    output cvb_pkg::cvb_out_s     outs,
    output logic                  bitStrobe
);

    // a bit instant reaches the outputs about four clocks after the clock
    // pin falls; data pins share the same chain depth, so they must be
    // settled at least one clock before that fall or the old level is taken

    // pins come from outside clk: one chain per pin
    logic [SYNC_LEN-1:0] clkSync_q;
    logic [SYNC_LEN-1:0] clkSync_d;
    logic                clkLevel_q;
    logic                clkLevel_d;
    logic [SYNC_LEN-1:0] encSync_q;
    logic [SYNC_LEN-1:0] encSync_d;
    logic                encLevel_q;
    logic                encLevel_d;
    logic [SYNC_LEN-1:0] cmpSync_q;
    logic [SYNC_LEN-1:0] cmpSync_d;
    logic                cmpLevel_q;
    logic                cmpLevel_d;
    logic [SYNC_LEN-1:0] rxSync_q;
    logic [SYNC_LEN-1:0] rxSync_d;
    logic                rxLevel_q;
    logic                rxLevel_d;

    // history and the registered outputs
    logic [HIST_LEN-1:0] hist_q;
    logic [HIST_LEN-1:0] hist_d;
    cvb_pkg::cvb_out_s   out_q;
    cvb_pkg::cvb_out_s   out_d;
    logic                strobe_q;
    logic                strobe_d;
    logic                fallEdge;
    logic                newBit;

    // one more sample into a chain, the oldest drops off the far end
    function automatic logic [SYNC_LEN-1:0] syncShift(input logic [SYNC_LEN-1:0] s,
                                                      input logic                pin);
        syncShift = {s[SYNC_LEN-2:0], pin};
    endfunction : syncShift

    // level follows only when the late stages agree, so a single
    // unsettled sample is never taken as a new level
    function automatic logic agreed(input logic [SYNC_LEN-1:0] s,
                                    input logic                prev);
        agreed = (s[SYNC_LEN-2] == s[SYNC_LEN-1]) ? s[SYNC_LEN-1] : prev;
    endfunction : agreed

    // newest bit enters at the low end
    function automatic logic [HIST_LEN-1:0] shiftIn(input logic [HIST_LEN-1:0] h,
                                                    input logic                b);
        shiftIn = {h[HIST_LEN-2:0], b};
    endfunction : shiftIn

    function automatic logic uniform(input logic [HIST_LEN-1:0] h);
        uniform = (&h) | ~(|h);
    endfunction : uniform

    // bit clock chain; reset low, so a clock pin high at release
    // shows up as a rise and never as a bit instant
    always_comb begin
        clkSync_d  = syncShift(clkSync_q, bitClk);
        clkLevel_d = agreed(clkSync_q, clkLevel_q);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            clkSync_q  <= {SYNC_LEN{cvb_pkg::SYNC_RESET}};
            clkLevel_q <= cvb_pkg::SYNC_RESET;
        end else begin
            clkSync_q  <= clkSync_d;
            clkLevel_q <= clkLevel_d;
        end
    end

    // encode or decode select chain
    always_comb begin
        encSync_d  = syncShift(encSync_q, encodeSelect);
        encLevel_d = agreed(encSync_q, encLevel_q);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            encSync_q  <= {SYNC_LEN{cvb_pkg::SYNC_RESET}};
            encLevel_q <= cvb_pkg::SYNC_RESET;
        end else begin
            encSync_q  <= encSync_d;
            encLevel_q <= encLevel_d;
        end
    end

    // comparator result chain
    always_comb begin
        cmpSync_d  = syncShift(cmpSync_q, inputAboveFeedback);
        cmpLevel_d = agreed(cmpSync_q, cmpLevel_q);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cmpSync_q  <= {SYNC_LEN{cvb_pkg::SYNC_RESET}};
            cmpLevel_q <= cvb_pkg::SYNC_RESET;
        end else begin
            cmpSync_q  <= cmpSync_d;
            cmpLevel_q <= cmpLevel_d;
        end
    end

    // received data chain
    always_comb begin
        rxSync_d  = syncShift(rxSync_q, rxData);
        rxLevel_d = agreed(rxSync_q, rxLevel_q);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rxSync_q  <= {SYNC_LEN{cvb_pkg::SYNC_RESET}};
            rxLevel_q <= cvb_pkg::SYNC_RESET;
        end else begin
            rxSync_q  <= rxSync_d;
            rxLevel_q <= rxLevel_d;
        end
    end

    // falling edge of the filtered bit clock marks one bit instant
    assign fallEdge = clkLevel_q & ~clkLevel_d;

    // inverted sense: one when input is below feedback
    assign newBit = (encLevel_q == cvb_pkg::MODE_ENCODE) ? ~cmpLevel_q
                                                         : rxLevel_q;

    // synchronous reset wins over a bit instant in the same cycle
    always_comb begin
        hist_d = hist_q;
        if (syncReset) begin
            hist_d = HIST_INIT;
        end else if (fallEdge) begin
            // one bit in per bit instant, no added bits, no framing state
            hist_d = shiftIn(hist_q, newBit);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hist_q <= HIST_INIT;
        end else begin
            hist_q <= hist_d;
        end
    end

    // outputs change only at a bit instant or a synchronous reset
    always_comb begin
        out_d = out_q;
        if (syncReset) begin
            out_d = cvb_pkg::OUT_RESET;
        end else if (fallEdge) begin
            out_d.serialBit     = newBit;
            out_d.rampUp        = newBit;
            // same check serves encode and decode paths
            out_d.coincidence_b = ~uniform(shiftIn(hist_q, newBit));
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            out_q <= cvb_pkg::OUT_RESET;
        end else begin
            out_q <= out_d;
        end
    end

    // one-cycle marker of the cycle in which the outputs took a new bit
    always_comb begin
        strobe_d = 1'h0;
        if (!syncReset && fallEdge) begin
            strobe_d = 1'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            strobe_q <= 1'h0;
        end else begin
            strobe_q <= strobe_d;
        end
    end

    // alternating bits never look uniform, so idle keeps the filter discharged
    assign outs      = out_q;
    assign bitStrobe = strobe_q;

endmodule : cvb_bit_history_core

// file: pkg/cvb_pkg.sv
// shared types and constants for the slope delta bit history core
package cvb_pkg;

    localparam int HIST_LEN = 3;
    localparam logic [HIST_LEN-1:0] HIST_RESET = 3'h2;
    localparam logic MODE_ENCODE = 1'h1;
    localparam logic SYNC_AGREE_MASK = 1'h1;
    localparam int SYNC_LEN = 3;
    localparam logic SYNC_RESET = 1'h0;

    typedef struct packed {
        logic serialBit;
        logic rampUp;
        logic coincidence_b;
    } cvb_out_s;

    localparam cvb_out_s OUT_RESET = 3'h1;

endpackage : cvb_pkg

// file: verification/cvb_rx_model.sv
// far-end decoder model keeping its own bit history
`timescale 1ns/10ps
module cvb_rx_model (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic syncReset,
    input  wire logic bitIn,
    input  wire logic bitStrobe,
    output logic      rxCoin_b
);
    logic [2:0] hist_q;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) hist_q <= 3'h2;
        else if (syncReset) hist_q <= 3'h2;
        else if (bitStrobe) hist_q <= {hist_q[1:0], bitIn};
    end
    assign rxCoin_b = !(&hist_q || ~|hist_q);
endmodule : cvb_rx_model

// file: verification/cvb_core_checker.sv
// assertions on the bit history core ports
`timescale 1ns/10ps
module cvb_core_checker (
    input wire logic              clk,
    input wire logic              rst_b,
    input wire logic              syncReset,
    input wire logic              bitClk,
    input wire logic              encodeSelect,
    input wire logic              inputAboveFeedback,
    input wire logic              rxData,
    input wire cvb_pkg::cvb_out_s outs,
    input wire logic              bitStrobe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic [1:0] hist_q;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) hist_q <= 2'h2;
        else if (syncReset) hist_q <= 2'h2;
        else if (bitStrobe) hist_q <= {hist_q[0], outs.serialBit};
    end
    ramp_dir_a: assert property (outs.rampUp == outs.serialBit) else $error("ramp");
    out_hold_a: assert property ($changed(outs) |-> bitStrobe || $past(syncReset))
        else $error("hold");
    coin_hist_a: assert property (bitStrobe |-> outs.coincidence_b ==
        !(hist_q == {2{outs.serialBit}})) else $error("coin");
    enc_sense_a: assert property (bitStrobe && $past(encodeSelect, 6) |->
        outs.serialBit == !$past(inputAboveFeedback, 6)) else $error("enc");
    dec_pass_a: assert property (bitStrobe && !$past(encodeSelect, 6) |->
        outs.serialBit == $past(rxData, 6)) else $error("dec");
    sync_init_a: assert property (syncReset |=> outs == 3'h1 && !bitStrobe)
        else $error("sreset");
    fall_lat_a: assert property ($fell(bitClk) |-> ##[3:6] bitStrobe) else $error("lat");
    one_bit_a: assert property (bitStrobe |=> !bitStrobe [*5]) else $error("gap");
    cover property (!outs.coincidence_b);
    cover property (bitStrobe && encodeSelect);
    cover property (syncReset);
endmodule : cvb_core_checker

bind cvb_bit_history_core cvb_core_checker chk_i (.*);

// file: verification/cvb_bit_history_core_test.sv
// self-checking bench for the bit history core
`timescale 1ns/10ps
module cvb_bit_history_core_test;
    logic clk = 0, rst_b = 0, syncReset = 0, bitClk = 0;
    logic encodeSelect = 0, inputAboveFeedback = 0, rxData = 0;
    cvb_pkg::cvb_out_s outs;
    logic bitStrobe, rxCoin_b;
    logic [2:0] hist = 3'h2;
    int bad_count = 0, compares = 0, cycles = 0;
    int strobes = 0, sent = 0, halfCyc = 8;
    cvb_bit_history_core DUT (
        .clk                (clk),
        .rst_b              (rst_b),
        .syncReset          (syncReset),
        .bitClk             (bitClk),
        .encodeSelect       (encodeSelect),
        .inputAboveFeedback (inputAboveFeedback),
        .rxData             (rxData),
        .outs               (outs),
        .bitStrobe          (bitStrobe)
    );
    cvb_rx_model far (.clk, .rst_b, .syncReset, .bitIn(outs.serialBit), .bitStrobe, .rxCoin_b);
    initial forever #2 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (bitStrobe === 1'h1) strobes <= strobes + 1;
        // some sixty short bits plus one slow bit stay well below this
        if (cycles == 8000) begin
            bad_count++;
            wrap_up();
        end
    end
    function automatic logic coinOf(input logic [2:0] h);
        return !(&h || ~|h);
    endfunction : coinOf
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
        compares++;
        if (s !== x) begin
            bad_count++;
            $display("[ERR] %s exp %0h got %0h", n, x, s);
        end
    endtask : chk
    task automatic bitc(input logic e, input logic a, input logic r);
        @(negedge clk);
        {encodeSelect, inputAboveFeedback, rxData, bitClk} = {e, a, r, 1'h1};
        repeat (halfCyc) @(negedge clk);
        bitClk = 0;
        hist = {hist[1:0], e ? !a : r};
        sent++;
        repeat (halfCyc) @(negedge clk);
        chk("serial", outs.serialBit, hist[0]);
        chk("ramp", outs.rampUp, hist[0]);
        chk("coin", outs.coincidence_b, coinOf(hist));
        chk("farCoin", rxCoin_b, coinOf(hist));
        chk("strobes", strobes, sent);
    endtask : bitc
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up
    initial begin
        int i;
        void'($urandom(54882));
        repeat (3) @(negedge clk);
        rst_b = 1;
        for (i = 0; i < 40; i++) bitc(1'($urandom), 1'($urandom), 1'($urandom));
        $display("random bits done");
        for (i = 0; i < 8; i++) bitc(i[2], 1'h0, 1'h1);
        for (i = 0; i < 6; i++) bitc(1'h1, outs.serialBit, 1'h0);
        chk("idleCoin", outs.coincidence_b, 1'h1);
        $display("runs and idle done");
        // mid-run loss: both ends restart from the alternating history
        rst_b = 0;
        @(negedge clk) rst_b = 1;
        hist = 3'h2;
        chk("rstOuts", outs, 3'h1);
        for (i = 0; i < 4; i++) bitc(1'($urandom), 1'($urandom), 1'($urandom));
        $display("restart done");
        syncReset = 1;
        @(negedge clk) syncReset = 0;
        hist = 3'h2;
        chk("rstCoin", outs.coincidence_b, 1'h1);
        chk("srstOuts", outs, 3'h1);
        bitc(1'h0, 1'h0, 1'h0);
        $display("sync reset done");
        // one bit near the top of the allowed bit clock band, about 64 kHz
        halfCyc = 1954;
        bitc(1'h1, 1'h1, 1'h0);
        $display("slow clock done");
        wrap_up();
    end
endmodule : cvb_bit_history_core_test
